// >>> src/acp_pkg.sv
// Package: register map, field layout and timing constants for the control
package acp_pkg;
   // Register byte offsets
   localparam logic [7:0] ACP_CFG_OFS = 8'h00;
   localparam logic [7:0] ACP_CTL_OFS = 8'h04;
   localparam logic [7:0] ACP_FLT_OFS = 8'h08;
   localparam logic [7:0] ACP_STAT_OFS = 8'h0C;
   localparam logic [7:0] ACP_COEF_OFS = 8'h10;
   localparam logic [7:0] ACP_PGD_OFS = 8'h14;
   localparam logic [7:0] ACP_UVDLY_OFS = 8'h18;
   // Config register fields
   localparam int ACP_CFG_EN = 0;
   localparam int ACP_CFG_REP = 1;
   localparam int ACP_CFG_STORE = 2;
   localparam int ACP_CFG_PGAFT = 3;
   localparam int ACP_CFG_GAIN = 4;
   // Mode bits sit above the 7-bit gain field so no gain value sets them
   localparam int ACP_CFG_STRAP = 16;
   localparam int ACP_CFG_USRSEL = 17;
   localparam int ACP_CFG_SINGLE = 18;
   localparam int ACP_CFG_DIODE = 19;
   localparam int ACP_CFG_EXTCLK = 20;
   // Fault register fields
   localparam int ACP_FLT_UVMODE = 0;
   localparam int ACP_FLT_OVMODE = 2;
   localparam int ACP_FLT_RETRY = 4;
   localparam int ACP_FLT_UVTH = 8;
   // Control register bits
   localparam int ACP_CTL_OUTEN = 0;
   localparam int ACP_CTL_RUNCMD = 1;
   localparam int ACP_CTL_RESTART = 2;
   // Gain settings in percent
   localparam logic [6:0] ACP_GAIN_MIN = 7'h0A;
   localparam logic [6:0] ACP_GAIN_MAX = 7'h64;
   localparam logic [6:0] ACP_GAIN_DEF = 7'h46;
   // Undervoltage modes
   localparam logic [1:0] ACP_UV_CONT = 2'h1;
   localparam logic [1:0] ACP_UV_DLY = 2'h2;
   localparam logic [1:0] ACP_UV_RETRY = 2'h3;
   localparam logic [1:0] ACP_UV_AUTO = 2'h0;
   // Overvoltage modes
   localparam logic [1:0] ACP_OV_AUTO = 2'h0;
   localparam logic [1:0] ACP_OV_RETRY = 2'h1;
   localparam logic [1:0] ACP_OV_OFF = 2'h2;
   // Threshold range in 100 mV steps: 2.85 V rounds up to 29, 16 V is 160
   localparam logic [7:0] ACP_UVTH_MIN = 8'h1D;
   localparam logic [7:0] ACP_UVTH_MAX = 8'hA0;
   localparam logic [7:0] ACP_UVTH_DEF = 8'h1D;
   localparam logic [31:0] ACP_CFG_RST = 32'h0000_0469;
   localparam logic [3:0] ACP_RETRY_DEF = 4'h3;
   localparam logic [15:0] ACP_PGD_DEF = 16'h0010;
   localparam logic [15:0] ACP_UVDLY_DEF = 16'h0010;
   localparam logic [15:0] ACP_COEF_DEF = 16'h1000;
   localparam logic [15:0] ACP_COEF_USR = 16'h0800;
endpackage

// >>> src/acp_control.sv
// Auto-compensation sequencer, power-good timing and fault responses
`timescale 1ns/100ps
//
// Behaviour
// - With storage on, save computed coefficients and return them on readback.
// - Repeat mode stores only the first run after ramp; later runs do not.
// - Stored coefficients are applied on every following ramp.
// - Repeat mode always regulates with the latest results.
// - Storage disable, which clears the store, is refused while output enabled.
// - Run command while enabled in store mode stores the next results.
// - Compensation off uses the factory or user coefficient set.
// - Delay policy: power-good after delay, then compensation starts.
// - After-compensation policy: power-good when first run ends, delay ignored.
// - Run once or periodically, with either power-good policy.
// - Results scaled by gain 10 to 100 percent.
// - Strap configuration allows only run-once mode, storage selectable.
// - Run-once without storage: power-good after compensation every start-up; with the delay policy the code raises power-good before the run.
// - Run-once with storage: later start-ups use store, power-good by delay.
// - Strap open defaults: run once, gain 70, power-good after run, no store.
// - Diode emulation only in single-phase operation.
// - Threshold programmable 2.85 to 16 V; operation inhibited below it.
// - Undervoltage: continue, delayed latched shutdown, or shutdown with retry.
// - Default undervoltage: immediate shutdown, re-enable when fault clears.
// - Overvoltage drops power-good, then retry shutdown or both switches off.
// - Default overvoltage auto re-enables; external clock forces that mode.
module acp_control
   import acp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ramp_done,
   input wire logic comp_done,
   input wire logic [15:0] comp_coeff,
   input wire logic [7:0] vin_level,
   input wire logic ov_trip,
   output logic comp_start,
   output logic [15:0] loop_coeff,
   output logic output_good_flag,
   output logic power_on,
   output logic switches_off,
   output logic diode_emul
);
   typedef enum logic [4:0] {
      ACP_OFF = 5'h01, ACP_RAMP = 5'h02, ACP_PGWAIT = 5'h04,
      ACP_COMP = 5'h08, ACP_REG = 5'h10
   } acp_state_t;

   typedef struct packed {
      acp_state_t st;
      logic [31:0] cfg;
      logic [31:0] flt;
      logic [15:0] pgd;
      logic [15:0] uvdly;
      logic out_en;
      logic store_valid;
      logic store_next;
      logic first_done;
      logic [15:0] store;
      logic [15:0] latest;
      logic [15:0] cnt;
      logic [15:0] uvcnt;
      logic [3:0] retries;
      logic uv_latched;
      logic ov_latched;
      logic dph;
      logic dwr;
      logic [7:0] daddr;
      logic [31:0] rdata;
      logic comp_start;
      logic [15:0] coeff;
      logic pg;
      logic pwr;
      logic sw_off;
      logic diode;
   } acp_s_t;

   acp_s_t s_r, s_nxt;

   // Scale a coefficient by gain percent, clamped to the legal range
   function automatic logic [15:0] acp_scale(input logic [15:0] c,
                                             input logic [6:0] g);
      logic [6:0] gc;
      logic [22:0] p;
      gc = (g < ACP_GAIN_MIN) ? ACP_GAIN_MIN :
           (g > ACP_GAIN_MAX) ? ACP_GAIN_MAX : g;
      p = c * gc;
      return 16'(p / 23'(ACP_GAIN_MAX));
   endfunction

   logic uv_low, ov_mode_auto, rep, store_en, pg_after;
   logic bus_take, w_outen, w_run, w_restart;

   //--------------------------------------------------------------------
   // Next-state logic
   //--------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.comp_start = 1'b0;
      bus_take = hsel && hready && htrans[1];
      uv_low = vin_level < s_r.flt[ACP_FLT_UVTH +: 8];
      // External clock leaves only immediate shutdown with auto re-enable
      ov_mode_auto = s_r.cfg[ACP_CFG_EXTCLK] ||
                     (s_r.flt[ACP_FLT_OVMODE +: 2] == ACP_OV_AUTO);
      // Strap-only configuration cannot select repeat mode
      rep = s_r.cfg[ACP_CFG_REP] && !s_r.cfg[ACP_CFG_STRAP];
      store_en = s_r.cfg[ACP_CFG_STORE];
      pg_after = s_r.cfg[ACP_CFG_PGAFT];
      w_outen = s_r.out_en;
      w_run = 1'b0;
      w_restart = 1'b0;
      // Data phase of a write
      if (s_r.dph && s_r.dwr) begin
         if (s_r.daddr == ACP_CFG_OFS) begin
            s_nxt.cfg = hwdata;
            // Disabling storage clears it, refused while enabled
            if (s_r.out_en && store_en) begin
               s_nxt.cfg[ACP_CFG_STORE] = 1'b1;
            end else if (!hwdata[ACP_CFG_STORE]) begin
               s_nxt.store_valid = 1'b0;
               s_nxt.first_done = 1'b0;
            end
         end else if (s_r.daddr == ACP_CTL_OFS) begin
            w_outen = hwdata[ACP_CTL_OUTEN];
            w_run = hwdata[ACP_CTL_RUNCMD];
            w_restart = hwdata[ACP_CTL_RESTART];
         end else if (s_r.daddr == ACP_FLT_OFS) begin
            s_nxt.flt = hwdata;
            // Threshold clamped into the supported range
            if (hwdata[ACP_FLT_UVTH +: 8] < ACP_UVTH_MIN)
               s_nxt.flt[ACP_FLT_UVTH +: 8] = ACP_UVTH_MIN;
            else if (hwdata[ACP_FLT_UVTH +: 8] > ACP_UVTH_MAX)
               s_nxt.flt[ACP_FLT_UVTH +: 8] = ACP_UVTH_MAX;
         end else if (s_r.daddr == ACP_PGD_OFS) begin
            s_nxt.pgd = hwdata[15:0];
         end else if (s_r.daddr == ACP_UVDLY_OFS) begin
            s_nxt.uvdly = hwdata[15:0];
         end
      end
      s_nxt.out_en = w_outen;
      if (w_run && s_r.out_en && store_en)
         s_nxt.store_next = 1'b1;
      if (w_restart) begin
         s_nxt.uv_latched = 1'b0;
         s_nxt.ov_latched = 1'b0;
         s_nxt.retries = s_r.flt[ACP_FLT_RETRY +: 4];
      end
      // Address phase capture
      s_nxt.dph = bus_take;
      s_nxt.dwr = hwrite;
      s_nxt.daddr = haddr[7:0];
      if (bus_take && !hwrite) begin
         if (haddr[7:0] == ACP_CFG_OFS) s_nxt.rdata = s_r.cfg;
         else if (haddr[7:0] == ACP_FLT_OFS) s_nxt.rdata = s_r.flt;
         else if (haddr[7:0] == ACP_CTL_OFS)
            s_nxt.rdata = {31'h0, s_r.out_en};
         else if (haddr[7:0] == ACP_STAT_OFS)
            s_nxt.rdata = {23'h0, s_r.st, s_r.uv_latched, s_r.ov_latched,
                           s_r.store_valid, s_r.pg};
         else if (haddr[7:0] == ACP_COEF_OFS)
            s_nxt.rdata = {s_r.latest, s_r.store};
         else if (haddr[7:0] == ACP_PGD_OFS) s_nxt.rdata = {16'h0, s_r.pgd};
         else if (haddr[7:0] == ACP_UVDLY_OFS)
            s_nxt.rdata = {16'h0, s_r.uvdly};
         else s_nxt.rdata = 32'h0;
      end
      // Time spent below threshold; the delayed shutdown counts from the
      // fault itself, since the sequencer counter restarts in OFF and on leaving RAMP and COMP
      s_nxt.uvcnt = !uv_low ? 16'h0 :
                    (s_r.uvcnt == 16'hFFFF) ? s_r.uvcnt : s_r.uvcnt + 16'h1;
      // Undervoltage response
      s_nxt.pwr = 1'b1;
      s_nxt.sw_off = 1'b0;
      if (uv_low) begin
         case (s_r.flt[ACP_FLT_UVMODE +: 2])
            ACP_UV_CONT: ;
            ACP_UV_DLY: begin
               // Run on for the delay, then latch off until restart
               if (s_r.uvcnt >= s_r.uvdly) s_nxt.uv_latched = 1'b1;
            end
            ACP_UV_RETRY: begin
               if (s_r.retries == 4'h0) s_nxt.uv_latched = 1'b1;
               else if (s_r.pwr) s_nxt.retries = s_r.retries - 4'h1;
               s_nxt.pwr = 1'b0;
            end
            default: s_nxt.pwr = 1'b0;
         endcase
      end
      if (s_r.uv_latched) s_nxt.pwr = 1'b0;
      // Overvoltage response
      if (ov_trip) begin
         if (ov_mode_auto) begin
            s_nxt.pwr = 1'b0;
         end else if (s_r.flt[ACP_FLT_OVMODE +: 2] == ACP_OV_OFF) begin
            s_nxt.ov_latched = 1'b1;
         end else begin
            // Retry: off while tripped, latch once retries run out
            if (s_r.retries == 4'h0) s_nxt.ov_latched = 1'b1;
            else if (s_r.pwr) s_nxt.retries = s_r.retries - 4'h1;
            s_nxt.pwr = 1'b0;
         end
      end
      if (s_r.ov_latched) begin
         if (s_r.flt[ACP_FLT_OVMODE +: 2] == ACP_OV_OFF) s_nxt.sw_off = 1'b1;
         else s_nxt.pwr = 1'b0;
      end
      if (!s_r.out_en) s_nxt.pwr = 1'b0;
      // Diode emulation gated by single-phase operation
      s_nxt.diode = s_r.cfg[ACP_CFG_DIODE] && s_r.cfg[ACP_CFG_SINGLE];
      // Sequencer
      s_nxt.cnt = (s_r.cnt == 16'hFFFF) ? s_r.cnt : s_r.cnt + 16'h1;
      case (s_r.st)
         ACP_OFF: begin
            s_nxt.pg = 1'b0;
            s_nxt.cnt = 16'h0;
            if (s_nxt.pwr && !s_nxt.sw_off) s_nxt.st = ACP_RAMP;
         end
         ACP_RAMP: if (ramp_done) begin
            s_nxt.cnt = 16'h0;
            // Stored values skip the run and use the delay
            if (!s_r.cfg[ACP_CFG_EN] || (store_en && s_r.store_valid && !rep
                && !s_r.store_next) || !pg_after)
               s_nxt.st = ACP_PGWAIT;
            else begin
               s_nxt.st = ACP_COMP;
               s_nxt.comp_start = 1'b1;
            end
         end
         ACP_PGWAIT: if (s_r.cnt >= s_r.pgd) begin
            s_nxt.pg = 1'b1;
            if (s_r.cfg[ACP_CFG_EN] && (rep || !(store_en && s_r.store_valid
                && !s_r.store_next))) begin
               s_nxt.st = ACP_COMP;
               s_nxt.comp_start = 1'b1;
            end else s_nxt.st = ACP_REG;
         end
         ACP_COMP: if (comp_done) begin
            s_nxt.latest = acp_scale(comp_coeff, s_r.cfg[ACP_CFG_GAIN +: 7]);
            s_nxt.pg = 1'b1;
            if (store_en && (!s_r.first_done || s_r.store_next)) begin
               s_nxt.store = acp_scale(comp_coeff,
                                       s_r.cfg[ACP_CFG_GAIN +: 7]);
               s_nxt.store_valid = 1'b1;
               // A run command landing now still arms the next result
               s_nxt.store_next = w_run && s_r.out_en;
               s_nxt.first_done = 1'b1;
            end
            s_nxt.st = ACP_REG;
            s_nxt.cnt = 16'h0;
         end
         // Periodic rerun, or a host run command, restarts the engine
         ACP_REG: if (s_r.cfg[ACP_CFG_EN] &&
                      ((rep && s_r.cnt >= s_r.pgd) || w_run)) begin
            s_nxt.st = ACP_COMP;
            s_nxt.comp_start = 1'b1;
         end
         default: s_nxt.st = ACP_OFF;
      endcase
      if (!s_nxt.pwr || ov_trip || s_nxt.sw_off) begin
         s_nxt.pg = 1'b0;
         if (!s_nxt.pwr) s_nxt.st = ACP_OFF;
      end
      // Coefficient selection
      if (!s_r.cfg[ACP_CFG_EN])
         s_nxt.coeff = s_r.cfg[ACP_CFG_USRSEL] ? ACP_COEF_USR
                                               : ACP_COEF_DEF;
      else if (rep || !s_r.store_valid || !store_en)
         s_nxt.coeff = s_nxt.latest;
      else
         s_nxt.coeff = s_r.store;
   end

   //--------------------------------------------------------------------
   // State register
   //--------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_r <= '0;
         s_r.st <= ACP_OFF;
         s_r.cfg <= ACP_CFG_RST;
         s_r.flt <= {16'h0, ACP_UVTH_DEF, ACP_RETRY_DEF, ACP_OV_AUTO,
                     ACP_UV_AUTO};
         s_r.pgd <= ACP_PGD_DEF;
         s_r.uvdly <= ACP_UVDLY_DEF;
         s_r.retries <= ACP_RETRY_DEF;
         s_r.coeff <= ACP_COEF_DEF;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from flip-flops; slave never waits
   assign hrdata = s_r.rdata;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign comp_start = s_r.comp_start;
   assign loop_coeff = s_r.coeff;
   assign output_good_flag = s_r.pg;
   assign power_on = s_r.pwr;
   assign switches_off = s_r.sw_off;
   assign diode_emul = s_r.diode;

   //--------------------------------------------------------------------
   // Assertions
   //--------------------------------------------------------------------
   a_ov_drops_pg: assert property (@(posedge hclk)
      disable iff (!hresetn) ov_trip |=> !output_good_flag)
      else $error("pg high after ov");
   a_diode_single: assert property (@(posedge hclk)
      disable iff (!hresetn) diode_emul |-> $past(s_r.cfg[ACP_CFG_SINGLE]))
      else $error("diode emulation without single phase");
   a_uv_inhibit: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (uv_low && s_r.flt[1:0] == ACP_UV_AUTO) |=> !power_on)
      else $error("power on under undervoltage");
   a_store_locked: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (s_r.out_en && s_r.cfg[ACP_CFG_STORE]) |=> s_r.cfg[ACP_CFG_STORE])
      else $error("store disabled while enabled");
   a_pg_after_comp: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (s_r.st == ACP_COMP && comp_done && !ov_trip && s_nxt.pwr
       && !s_nxt.sw_off) |=> output_good_flag)
      else $error("pg not raised after compensation");
   a_store_kept: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (s_r.first_done && !s_r.store_next && !(s_r.dph && s_r.dwr))
      |=> $stable(s_r.store)) else $error("store overwritten");
   a_fixed_coeff: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (!s_r.cfg[ACP_CFG_EN] && !s_r.cfg[ACP_CFG_USRSEL]) |=>
      loop_coeff == ACP_COEF_DEF) else $error("wrong default set");
   a_start_pulse: assert property (@(posedge hclk)
      disable iff (!hresetn) comp_start |=> !comp_start)
      else $error("start not a pulse");
   a_ov_off_latch: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (s_r.ov_latched && s_r.flt[ACP_FLT_OVMODE +: 2] == ACP_OV_OFF) |=>
      switches_off) else $error("switches on while latched off");
   a_use_store: assert property (@(posedge hclk)
      disable iff (!hresetn)
      (s_r.cfg[ACP_CFG_EN] && !rep && store_en && s_r.store_valid) |=>
      loop_coeff == $past(s_r.store)) else $error("stored set not used");
endmodule // acp_control

// >>> bench/acp_stage_model.sv
// Power stage model: output ramp and compensation engine
`timescale 1ns/100ps
module acp_stage_model #(
   parameter int RAMP_CYC = 20
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic power_on,
   input wire logic comp_start,
   input wire logic slow,
   input wire logic [15:0] raw,
   output logic ramp_done,
   output logic comp_done,
   output logic [15:0] comp_coeff
);
   int rc;
   int cc;
   // Ramp ends a fixed time after power-up; engine answers fast or slow.
   // Outside the done pulse the coefficient bus toggles so that a design
   // that samples it at the wrong moment picks up garbage.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rc <= 0;
         cc <= 0;
         ramp_done <= 1'b0;
         comp_done <= 1'b0;
         comp_coeff <= 16'h0000;
      end else begin
         rc <= power_on ? (rc < RAMP_CYC ? rc + 1 : rc) : 0;
         ramp_done <= power_on && rc >= RAMP_CYC;
         comp_done <= cc == 1;
         comp_coeff <= (cc == 1) ? raw : ~comp_coeff;
         if (comp_start)
            cc <= slow ? 40 : 6;
         else if (cc > 0)
            cc <= cc - 1;
      end
   end
endmodule // acp_stage_model

// >>> bench/tb_acp_control.sv
// Testbench: register-driven checks of compensation, power-good and faults
`timescale 1ns/100ps
module tb_acp_control import acp_pkg::*;;
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic hclk, hresetn, hsel, hwrite, ov_trip, slow;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic hreadyout, ramp_done, comp_done, comp_start;
   logic power_on, switches_off, diode_emul, output_good_flag;
   logic [15:0] comp_coeff, loop_coeff, raw;
   logic [7:0] vin_level;
   logic [3:0] mon;
   logic [6:0] g;
   int fails, total_checks, wn, cs_cnt, cd_cnt, c0, i;
   logic [31:0] cfgt [4] = '{32'h0, 32'h2_0000, 32'hC_0000, 32'h8_0000};
   logic [31:0] ovt [4] = '{32'h0, 32'h4, 32'h8, 32'h8};
   `define CHK(n, e, a) chk(n, 32'(e), 32'(a))
   // Status bits in one vector so one wait task serves them all
   assign mon = {diode_emul, switches_off, power_on, output_good_flag};

   acp_control dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .ramp_done(ramp_done),
      .comp_done(comp_done), .comp_coeff(comp_coeff),
      .vin_level(vin_level), .ov_trip(ov_trip), .comp_start(comp_start),
      .loop_coeff(loop_coeff), .output_good_flag(output_good_flag),
      .power_on(power_on), .switches_off(switches_off),
      .diode_emul(diode_emul));
   acp_stage_model stage (.hclk(hclk), .hresetn(hresetn),
      .power_on(power_on), .comp_start(comp_start), .slow(slow),
      .raw(raw), .ramp_done(ramp_done), .comp_done(comp_done),
      .comp_coeff(comp_coeff));

   // Clock, 40 ns period
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end
   // Run and done counters; non-blocking so the tests see settled counts
   always @(posedge hclk) begin
      if (comp_start === 1'b1)
         cs_cnt <= cs_cnt + 1;
      if (comp_done === 1'b1)
         cd_cnt <= cd_cnt + 1;
   end
   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task chk(string n, logic [31:0] e, logic [31:0] a);
      total_checks++;
      if (a !== e) begin
         fails++;
         $display("unexpected %s: exp %h got %h", n, e, a);
      end
   endtask
   // Single word transfer; master waits on hready in both phases
   task ahb(logic w, logic [7:0] a, logic [31:0] d);
      hsel <= 1'b1;
      hwrite <= w;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask
   task wr(logic [7:0] a, logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task rd(logic [7:0] a);
      ahb(1'b0, a, 32'h0);
   endtask
   // Bounded wait for one status bit; wn keeps the cycles spent
   task wt(int b, logic v, string n);
      wn = 0;
      while (mon[b] !== v && wn < 3000) begin
         @(posedge hclk);
         wn++;
      end
      `CHK(n, v, mon[b]);
   endtask
   task tend(string s);
      $display("test %s done", s);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog: the tests need well under a tenth of this span
   initial begin
      repeat (60000) @(posedge hclk);
      fails++;
      test_done;
   end
   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      vin_level = 8'h60;
      ov_trip = 1'b0;
      slow = 1'b0;
      raw = 16'h1234;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(ACP_CFG_OFS);
      `CHK("cfg mode", 4'h9, rdv[3:0]);
      `CHK("cfg gain", ACP_GAIN_DEF, rdv[10:4]);
      rd(8'h40);
      `CHK("unmapped", 32'h0, rdv);
      tend("reset");
      // Fixed coefficient sets and diode emulation gating
      for (i = 0; i < 4; i++) begin
         wr(ACP_CTL_OFS, 32'h0);
         wr(ACP_CFG_OFS, cfgt[i]);
         wr(ACP_CTL_OFS, 32'h1);
         repeat (30) @(posedge hclk);
         `CHK("fixed", i == 1 ? ACP_COEF_USR : ACP_COEF_DEF, loop_coeff);
         `CHK("diode", i == 2, diode_emul);
      end
      tend("fixed");
      // Delay policy: power-good first, only then a run
      wr(ACP_CTL_OFS, 32'h0);
      wr(ACP_PGD_OFS, 32'd50);
      wr(ACP_CFG_OFS, 32'h641);
      c0 = cs_cnt;
      wr(ACP_CTL_OFS, 32'h1);
      wt(0, 1'b1, "pg delay");
      `CHK("pg held", 1, wn >= 50);
      `CHK("no run", c0, cs_cnt);
      c0 = cd_cnt;
      repeat (100) @(posedge hclk);
      `CHK("run after", 1, cd_cnt > c0);
      `CHK("coef", raw, loop_coeff);
      tend("pg delay");
      // After-run policy on two start-ups, both gain limits
      wr(ACP_PGD_OFS, 32'd400);
      for (i = 0; i < 2; i++) begin
         g = i ? ACP_GAIN_MIN : ACP_GAIN_MAX;
         wr(ACP_CTL_OFS, 32'h0);
         wr(ACP_CFG_OFS, 32'({g, 4'h9}));
         c0 = cd_cnt;
         wr(ACP_CTL_OFS, 32'h1);
         wt(0, 1'b1, "pg run");
         `CHK("pg early", 1, wn < 400 && cd_cnt > c0);
         `CHK("gain", raw * g / 100, loop_coeff);
      end
      tend("pg after run");
      // Store: save, refused clear, rerun overwrite, later start-up
      wr(ACP_CTL_OFS, 32'h0);
      wr(ACP_PGD_OFS, 32'd60);
      wr(ACP_CFG_OFS, 32'h64D);
      wr(ACP_CTL_OFS, 32'h1);
      wt(0, 1'b1, "pg first");
      rd(ACP_COEF_OFS);
      `CHK("stored", raw, rdv[15:0]);
      wr(ACP_CFG_OFS, 32'h649);
      rd(ACP_CFG_OFS);
      `CHK("store kept", 1, rdv[ACP_CFG_STORE]);
      raw <= 16'h0ABC;
      wr(ACP_CTL_OFS, 32'h3);
      repeat (60) @(posedge hclk);
      rd(ACP_COEF_OFS);
      `CHK("restored", 16'h0ABC, rdv[15:0]);
      wr(ACP_CTL_OFS, 32'h0);
      raw <= 16'h0111;
      wt(0, 1'b0, "pg off");
      wr(ACP_CTL_OFS, 32'h1);
      wt(0, 1'b1, "pg later");
      `CHK("pg by delay", 1, wn >= 60);
      `CHK("use store", 16'h0ABC, loop_coeff);
      tend("store");
      // Repeat mode with a slow engine; clear store while off
      wr(ACP_CTL_OFS, 32'h0);
      wr(ACP_CFG_OFS, 32'h0);
      rd(ACP_STAT_OFS);
      `CHK("store clr", 0, rdv[1]);
      slow <= 1'b1;
      raw <= 16'h2222;
      wr(ACP_PGD_OFS, 32'd80);
      wr(ACP_CFG_OFS, 32'h64F);
      wr(ACP_CTL_OFS, 32'h1);
      wt(0, 1'b1, "pg rep");
      raw <= 16'h3333;
      repeat (300) @(posedge hclk);
      `CHK("latest", 16'h3333, loop_coeff);
      rd(ACP_COEF_OFS);
      `CHK("first kept", 16'h2222, rdv[15:0]);
      `CHK("latest rd", 16'h3333, rdv[31:16]);
      tend("repeat");
      // Strap-only setting ignores the repeat request
      slow <= 1'b0;
      wr(ACP_CTL_OFS, 32'h0);
      wr(ACP_CFG_OFS, 32'h1_000B);
      wr(ACP_CTL_OFS, 32'h1);
      wt(0, 1'b1, "pg strap");
      c0 = cs_cnt;
      repeat (300) @(posedge hclk);
      `CHK("once", c0, cs_cnt);
      tend("strap");
      // Undervoltage modes 0..3 with threshold 8.0 V, boundary on recovery
      wr(ACP_CTL_OFS, 32'h0);
      wr(ACP_CFG_OFS, 32'h0);
      wr(ACP_UVDLY_OFS, 32'd20);
      for (i = 0; i < 4; i++) begin
         wr(ACP_FLT_OFS, 32'h5030 | i);
         wr(ACP_CTL_OFS, 32'h1);
         wt(1, 1'b1, "uv on");
         vin_level <= 8'h4F;
         repeat (10) @(posedge hclk);
         `CHK("uv early", i == 1 || i == 2, power_on);
         repeat (30) @(posedge hclk);
         `CHK("uv late", i == 1, power_on);
         vin_level <= 8'h50;
         repeat (40) @(posedge hclk);
         `CHK("uv back", i != 2, power_on);
         wr(ACP_CTL_OFS, 32'h5);
         wt(1, 1'b1, "uv restart");
      end
      vin_level <= 8'h60;
      tend("undervoltage");
      // Overvoltage: auto, retry, switches off, external clock forced
      wr(ACP_PGD_OFS, 32'd30);
      for (i = 0; i < 4; i++) begin
         wr(ACP_CTL_OFS, 32'h0);
         wr(ACP_CFG_OFS, i == 3 ? 32'h10_0000 : 32'h0);
         wr(ACP_FLT_OFS, 32'h5030 | ovt[i]);
         wr(ACP_CTL_OFS, 32'h1);
         wt(0, 1'b1, "pg ov");
         ov_trip <= 1'b1;
         wt(0, 1'b0, "pg drop");
         repeat (10) @(posedge hclk);
         `CHK("fets off", i == 2, switches_off);
         `CHK("ov shut", 1, i == 2 || power_on === 1'b0);
         ov_trip <= 1'b0;
         repeat (40) @(posedge hclk);
         `CHK("ov clear", i != 2, power_on === 1'b1 && !switches_off);
         wr(ACP_CTL_OFS, 32'h5);
         wt(2, 1'b0, "ov restart");
      end
      tend("overvoltage");
      test_done;
   end
endmodule // tb_acp_control
